// ---- design/fbls_pkg.sv ----
// Constants shared by the block-lock host controller: register map, codes, timing.
// Assumes a 50 MHz system clock and an x16 flash whose command byte sits on the low lane.
package fbls_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and flash bus timing; times in ns, counts derived and rounded up.
	localparam int CLK_PERIOD_NS = 20;
	localparam int T_ADDR_SETUP_NS = 20;
	localparam int T_WE_LOW_NS = 50;
	localparam int T_WE_HIGH_NS = 30;
	localparam int T_READ_NS = 80;
	localparam logic [7:0] SETUP_CYC =
		8'((T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] WE_LOW_CYC = 8'((T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] WE_HIGH_CYC =
		8'((T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] READ_CYC = 8'((T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets of the controller's own APB slave.
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_PINS = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;

	// Reset values of the software-written registers.
	localparam logic [1:0] PINS_RESET = 2'h0;
	localparam logic [2:0] OP_RESET = 3'h0;

	// Fields of the command register and the pin register.
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_CODE_LSB = 8;
	localparam int PINS_WP_BIT = 0;
	localparam int PINS_DEVRST_BIT = 1;

	// Operation codes written to the command register.
	localparam logic [2:0] OP_LOCK = 3'h0;
	localparam logic [2:0] OP_UNLOCK = 3'h1;
	localparam logic [2:0] OP_LOCKDOWN = 3'h2;
	localparam logic [2:0] OP_STATUS = 3'h3;
	localparam logic [2:0] OP_CLEAR = 3'h4;
	localparam logic [2:0] OP_LOCK_READ = 3'h5;
	localparam logic [2:0] OP_RAW = 3'h6;

	////////////////////////////////////////////////////////////////////////////////
	// Flash command bytes.
	localparam logic [7:0] FC_CONF_SETUP = 8'h60;
	localparam logic [7:0] FC_LOCK = 8'h01;
	localparam logic [7:0] FC_UNLOCK = 8'hd0;
	localparam logic [7:0] FC_LOCKDOWN = 8'h2f;
	localparam logic [7:0] FC_READ_STAT = 8'h70;
	localparam logic [7:0] FC_CLEAR_STAT = 8'h50;
	localparam logic [7:0] FC_READ_CONF = 8'h90;

	// Lock status word sits two words above the block base.
	localparam int LOCK_STAT_OFFSET = 2;

	// Bit positions of the operation_status byte.
	localparam int SR_READY = 7;
	localparam int SR_ESUSP = 6;
	localparam int SR_EERR = 5;
	localparam int SR_PERR = 4;
	localparam int SR_SUPPLY = 3;
	localparam int SR_PSUSP = 2;
	localparam int SR_LOCKERR = 1;
	localparam int SR_RSVD = 0;

	// Bit positions in the status summary register.
	localparam int ST_BUSY = 16;
	localparam int ST_REFUSED = 17;
	localparam int ST_LOCK = 18;
	localparam int ST_LOCKDOWN = 19;

endpackage

// ---- design/fbls_cyc_if.sv ----
// Carrier between the sequencer and the flash bus cycle engine.
// Assumes both ends run on clk_sys; req is a one-cycle pulse taken only while the engine idles.
`timescale 1ns/10ps
interface fbls_cyc_if #(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16
);
	logic              req;
	logic              wr;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              done;
	logic [DATA_W-1:0] rdata;

	modport ctrl (output req, output wr, output addr, output wdata, input done, input rdata);
	modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// ---- design/fbls_cycle.sv ----
// Flash bus cycle engine: one write or one read cycle on the flash pins per request.
// Assumes flash inputs are synchronous to clk_sys; all pins leave from flip-flops.
`timescale 1ns/10ps
module fbls_cycle #(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	fbls_cyc_if.eng                cyc,
	output logic [ADDR_W-1:0]      fl_addr,
	output logic [DATA_W-1:0]      fl_dq_o,
	output logic                   fl_dq_oe_n,
	input  wire logic [DATA_W-1:0] fl_dq_i,
	output logic                   fl_ce_n,
	output logic                   fl_we_n,
	output logic                   fl_oe_n
);
	typedef enum logic [2:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD, C_RECOV} fbls_cyc_e;

	localparam logic [7:0] SETUP_CYC_L = fbls_pkg::SETUP_CYC;

	fbls_cyc_e         state_ff, nxt_state;
	logic [7:0]        cnt_ff, nxt_cnt;
	logic              wr_ff, nxt_wr;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [DATA_W-1:0] wdat_ff, nxt_wdat, rdat_ff, nxt_rdat;
	logic              ce_n_ff, nxt_ce_n, we_n_ff, nxt_we_n, oe_n_ff, nxt_oe_n;
	logic              oe_dq_n_ff, nxt_oe_dq_n, done_ff, nxt_done;

	////////////////////////////////////////////////////////////////////////////////
	// Cycle sequencer: setup, strobe, hold, then recovery with the bus released.
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_wr = wr_ff;
		nxt_addr = addr_ff;
		nxt_wdat = wdat_ff;
		nxt_rdat = rdat_ff;
		nxt_ce_n = ce_n_ff;
		nxt_we_n = we_n_ff;
		nxt_oe_n = oe_n_ff;
		nxt_oe_dq_n = oe_dq_n_ff;
		nxt_done = 1'b0;
		case (state_ff)
			C_IDLE:
			begin
				if (cyc.req)
				begin
					nxt_wr = cyc.wr;
					nxt_addr = cyc.addr;
					nxt_wdat = cyc.wdata;
					nxt_ce_n = 1'b0;
					nxt_oe_n = cyc.wr;         // Reads open the output enable at once.
					nxt_oe_dq_n = ~cyc.wr;     // Writes drive the data lines.
					nxt_cnt = SETUP_CYC_L;
					nxt_state = C_SETUP;
				end
			end
			C_SETUP:
			begin
				if (cnt_ff == 8'h01)
				begin
					nxt_we_n = ~wr_ff;
					nxt_cnt = wr_ff ? fbls_pkg::WE_LOW_CYC : fbls_pkg::READ_CYC;
					nxt_state = C_STROBE;
				end
				else
					nxt_cnt = cnt_ff - 8'h01;
			end
			C_STROBE:
			begin
				if (cnt_ff == 8'h01)
				begin
					nxt_we_n = 1'b1;
					nxt_rdat = wr_ff ? rdat_ff : fl_dq_i;
					nxt_oe_n = 1'b1;
					nxt_state = C_HOLD;
				end
				else
					nxt_cnt = cnt_ff - 8'h01;
			end
			C_HOLD:
			begin
				// Data held one cycle past the rising write strobe, then released.
				nxt_ce_n = 1'b1;
				nxt_oe_dq_n = 1'b1;
				nxt_cnt = fbls_pkg::WE_HIGH_CYC;
				nxt_state = C_RECOV;
			end
			C_RECOV:
			begin
				if (cnt_ff == 8'h01)
				begin
					nxt_done = 1'b1;
					nxt_state = C_IDLE;
				end
				else
					nxt_cnt = cnt_ff - 8'h01;
			end
			default:
				nxt_state = C_IDLE;
		endcase
	end

	// Registers of the cycle engine; pins idle deasserted.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= C_IDLE;
			cnt_ff <= 8'h00;
			wr_ff <= 1'b0;
			addr_ff <= '0;
			wdat_ff <= '0;
			rdat_ff <= '0;
			ce_n_ff <= 1'b1;
			we_n_ff <= 1'b1;
			oe_n_ff <= 1'b1;
			oe_dq_n_ff <= 1'b1;
			done_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			wr_ff <= nxt_wr;
			addr_ff <= nxt_addr;
			wdat_ff <= nxt_wdat;
			rdat_ff <= nxt_rdat;
			ce_n_ff <= nxt_ce_n;
			we_n_ff <= nxt_we_n;
			oe_n_ff <= nxt_oe_n;
			oe_dq_n_ff <= nxt_oe_dq_n;
			done_ff <= nxt_done;
		end
	end

	assign fl_addr = addr_ff;
	assign fl_dq_o = wdat_ff;
	assign fl_dq_oe_n = oe_dq_n_ff;
	assign fl_ce_n = ce_n_ff;
	assign fl_we_n = we_n_ff;
	assign fl_oe_n = oe_n_ff;
	assign cyc.done = done_ff;
	assign cyc.rdata = rdat_ff;
endmodule

// ---- design/fbls_stat.sv ----
// Status decoder: holds the last status byte and lock bits read from the flash.
// Assumes capture strobes are one-cycle pulses carrying valid read data.
`timescale 1ns/10ps
module fbls_stat (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       cap_stat,
	input  wire logic       cap_lock,
	input  wire logic [7:0] rd_byte,
	output logic [15:0]     summary,
	output logic [1:0]      lock_bits
);
	logic [15:0] sum_ff, nxt_sum;
	logic [1:0]  lock_ff, nxt_lock;
	logic [7:0]  sr;

	////////////////////////////////////////////////////////////////////////////////
	// Decode a fresh status byte; error bits only count once the engine is ready.
	always_comb
	begin
		sr = rd_byte;
		sr[fbls_pkg::SR_RSVD] = 1'b0;
		nxt_sum = sum_ff;
		nxt_lock = lock_ff;
		if (cap_stat)
		begin
			nxt_sum[7:0] = sr;
			nxt_sum[8] = sr[fbls_pkg::SR_READY];
			nxt_sum[9] = sr[fbls_pkg::SR_READY] & sr[fbls_pkg::SR_PERR];
			nxt_sum[10] = sr[fbls_pkg::SR_READY] & sr[fbls_pkg::SR_EERR];
			nxt_sum[11] = sr[fbls_pkg::SR_READY] & sr[fbls_pkg::SR_PERR]
				& sr[fbls_pkg::SR_EERR];
			nxt_sum[12] = sr[fbls_pkg::SR_READY] & sr[fbls_pkg::SR_SUPPLY];
			nxt_sum[13] = sr[fbls_pkg::SR_READY] & sr[fbls_pkg::SR_LOCKERR];
			nxt_sum[14] = sr[fbls_pkg::SR_PSUSP];
			nxt_sum[15] = sr[fbls_pkg::SR_ESUSP];
		end
		if (cap_lock)
			nxt_lock = rd_byte[1:0];
	end

	// Registers of the decoder; after reset the blocks are assumed locked.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sum_ff <= 16'h0000;
			lock_ff <= 2'h1;
		end
		else
		begin
			sum_ff <= nxt_sum;
			lock_ff <= nxt_lock;
		end
	end

	assign summary = sum_ff;
	assign lock_bits = lock_ff;
endmodule

// ---- design/fbls_host.sv ----
// Host controller for a flash with per-block locking: APB slave plus command sequencer.
// Assumes the flash pins are synchronous to clk_sys and the bench resolves the data wire.
//
// How it works
// - Host masks reserved status bit 0.
// - Host checks ready before error bits.
// - Lock is 60H then 01H at block.
// - Unlock is 60H then D0H at block.
// - Lockdown is 60H then 2FH at block.
`timescale 1ns/10ps
module fbls_host #(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic [ADDR_W-1:0]      fl_addr,
	output logic [DATA_W-1:0]      fl_dq_o,
	output logic                   fl_dq_oe_n,
	input  wire logic [DATA_W-1:0] fl_dq_i,
	output logic                   fl_ce_n,
	output logic                   fl_we_n,
	output logic                   fl_oe_n,
	output logic                   fl_wp,
	output logic                   fl_rst_n
);
	typedef enum logic [1:0] {H_IDLE, H_REQ, H_WAIT} fbls_seq_e;

	fbls_cyc_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) cyc ();

	fbls_seq_e         state_ff, nxt_state;
	logic              step_ff, nxt_step;
	logic              two_ff, nxt_two;
	logic              s1_wr_ff, nxt_s1_wr;
	logic [ADDR_W-1:0] s1_addr_ff, nxt_s1_addr;
	logic [7:0]        s0_code_ff, nxt_s0_code, s1_code_ff, nxt_s1_code;
	logic [2:0]        op_ff, nxt_op;
	logic [7:0]        raw_ff, nxt_raw;
	logic [ADDR_W-1:0] blk_ff, nxt_blk;
	logic [1:0]        pins_ff, nxt_pins;
	logic              flrst_n_ff, nxt_flrst_n;
	logic              refused_ff, nxt_refused;
	logic              req_ff, nxt_req;
	logic              cap_stat_ff, nxt_cap_stat, cap_lock_ff, nxt_cap_lock;
	logic [31:0]       prdata_ff, nxt_prdata;
	logic              pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
	logic              access, commit, mapped, start;
	logic [2:0]        new_op;
	logic [15:0]       summary;
	logic [1:0]        lock_bits;

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state, then data and error answer from flip-flops.
	always_comb
	begin
		access = psel & penable & ~pready_ff;
		commit = psel & penable & pready_ff;
		mapped = (paddr == fbls_pkg::OFF_CMD) | (paddr == fbls_pkg::OFF_ADDR)
			| (paddr == fbls_pkg::OFF_PINS) | (paddr == fbls_pkg::OFF_STAT);
		nxt_pready = access;
		nxt_pslverr = access & ~mapped;
		nxt_prdata = prdata_ff;
		if (access)
		begin
			case (paddr)
				fbls_pkg::OFF_CMD:  nxt_prdata = {16'h0000, raw_ff, 5'h00, op_ff};
				fbls_pkg::OFF_ADDR: nxt_prdata = 32'(blk_ff);
				fbls_pkg::OFF_PINS: nxt_prdata = {30'h0, pins_ff};
				fbls_pkg::OFF_STAT: nxt_prdata = {12'h000, lock_bits, refused_ff,
					(state_ff != H_IDLE), summary};
				default:            nxt_prdata = 32'h0000_0000;
			endcase
		end
	end

	// Register writes; a command written while a sequence runs is refused.
	always_comb
	begin
		new_op = pwdata[fbls_pkg::CMD_OP_LSB +: 3];
		start = commit & pwrite & (paddr == fbls_pkg::OFF_CMD) & (state_ff == H_IDLE)
			& (new_op <= fbls_pkg::OP_RAW);
		nxt_op = op_ff;
		nxt_raw = raw_ff;
		nxt_blk = blk_ff;
		nxt_pins = pins_ff;
		nxt_refused = refused_ff;
		if (commit & pwrite)
		begin
			if (paddr == fbls_pkg::OFF_ADDR)
				nxt_blk = pwdata[ADDR_W-1:0];
			if (paddr == fbls_pkg::OFF_PINS)
				nxt_pins = pwdata[1:0];
			if ((paddr == fbls_pkg::OFF_CMD) & ~start)
				nxt_refused = 1'b1;
		end
		if (start)
		begin
			nxt_op = new_op;
			nxt_raw = pwdata[fbls_pkg::CMD_CODE_LSB +: 8];
			nxt_refused = 1'b0;
		end
		nxt_flrst_n = ~nxt_pins[fbls_pkg::PINS_DEVRST_BIT];   // Own flop keeps the pin glitch free.
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command sequencer: each operation is one or two flash bus cycles.
	always_comb
	begin
		nxt_state = state_ff;
		nxt_step = step_ff;
		nxt_two = two_ff;
		nxt_s1_wr = s1_wr_ff;
		nxt_s1_addr = s1_addr_ff;
		nxt_s0_code = s0_code_ff;
		nxt_s1_code = s1_code_ff;
		nxt_req = 1'b0;
		nxt_cap_stat = 1'b0;
		nxt_cap_lock = 1'b0;
		case (state_ff)
			H_IDLE:
			begin
				if (start)
				begin
					nxt_step = 1'b0;
					nxt_two = 1'b1;
					nxt_s1_wr = 1'b1;
					nxt_s1_addr = blk_ff;
					nxt_s0_code = fbls_pkg::FC_CONF_SETUP;
					nxt_s1_code = 8'h00;
					case (new_op)
						fbls_pkg::OP_LOCK:     nxt_s1_code = fbls_pkg::FC_LOCK;
						fbls_pkg::OP_UNLOCK:   nxt_s1_code = fbls_pkg::FC_UNLOCK;
						fbls_pkg::OP_LOCKDOWN: nxt_s1_code = fbls_pkg::FC_LOCKDOWN;
						fbls_pkg::OP_STATUS:
						begin
							nxt_s0_code = fbls_pkg::FC_READ_STAT;
							nxt_s1_wr = 1'b0;
						end
						fbls_pkg::OP_CLEAR:
						begin
							nxt_s0_code = fbls_pkg::FC_CLEAR_STAT;
							nxt_two = 1'b0;
						end
						fbls_pkg::OP_LOCK_READ:
						begin
							nxt_s0_code = fbls_pkg::FC_READ_CONF;
							nxt_s1_wr = 1'b0;
							nxt_s1_addr = blk_ff + ADDR_W'(fbls_pkg::LOCK_STAT_OFFSET);
						end
						default:
						begin
							// Raw code lets software provoke a sequence error on purpose.
							nxt_s0_code = pwdata[fbls_pkg::CMD_CODE_LSB +: 8];
							nxt_two = 1'b0;
						end
					endcase
					nxt_req = 1'b1;
					nxt_state = H_REQ;
				end
			end
			H_REQ:
				nxt_state = H_WAIT;
			H_WAIT:
			begin
				if (cyc.done)
				begin
					if (two_ff & ~step_ff)
					begin
						nxt_step = 1'b1;
						nxt_req = 1'b1;
						nxt_state = H_REQ;
					end
					else
					begin
						// Lock changes need no busy poll; the sequence ends here.
						nxt_cap_stat = step_ff & (op_ff == fbls_pkg::OP_STATUS);
						nxt_cap_lock = step_ff & (op_ff == fbls_pkg::OP_LOCK_READ);
						nxt_state = H_IDLE;
					end
				end
			end
			default:
				nxt_state = H_IDLE;
		endcase
	end

	// Cycle request fields follow the current step.
	assign cyc.req = req_ff;
	assign cyc.wr = step_ff ? s1_wr_ff : 1'b1;
	assign cyc.addr = step_ff ? s1_addr_ff : blk_ff;
	assign cyc.wdata = DATA_W'(step_ff ? s1_code_ff : s0_code_ff);

	////////////////////////////////////////////////////////////////////////////////
	// Registers of the slave, the sequencer and the pin controls.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= H_IDLE;
			step_ff <= 1'b0;
			two_ff <= 1'b0;
			s1_wr_ff <= 1'b1;
			s1_addr_ff <= '0;
			s0_code_ff <= 8'h00;
			s1_code_ff <= 8'h00;
			op_ff <= fbls_pkg::OP_RESET;
			raw_ff <= 8'h00;
			blk_ff <= '0;
			pins_ff <= fbls_pkg::PINS_RESET;
			flrst_n_ff <= 1'b1;
			refused_ff <= 1'b0;
			req_ff <= 1'b0;
			cap_stat_ff <= 1'b0;
			cap_lock_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			step_ff <= nxt_step;
			two_ff <= nxt_two;
			s1_wr_ff <= nxt_s1_wr;
			s1_addr_ff <= nxt_s1_addr;
			s0_code_ff <= nxt_s0_code;
			s1_code_ff <= nxt_s1_code;
			op_ff <= nxt_op;
			raw_ff <= nxt_raw;
			blk_ff <= nxt_blk;
			pins_ff <= nxt_pins;
			flrst_n_ff <= nxt_flrst_n;
			refused_ff <= nxt_refused;
			req_ff <= nxt_req;
			cap_stat_ff <= nxt_cap_stat;
			cap_lock_ff <= nxt_cap_lock;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign fl_wp = pins_ff[fbls_pkg::PINS_WP_BIT];
	assign fl_rst_n = flrst_n_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Bus cycle engine and status decoder.
	fbls_cycle #(
		.ADDR_W (ADDR_W),
		.DATA_W (DATA_W)
	) u_cycle (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.cyc        (cyc.eng),
		.fl_addr    (fl_addr),
		.fl_dq_o    (fl_dq_o),
		.fl_dq_oe_n (fl_dq_oe_n),
		.fl_dq_i    (fl_dq_i),
		.fl_ce_n    (fl_ce_n),
		.fl_we_n    (fl_we_n),
		.fl_oe_n    (fl_oe_n)
	);

	fbls_stat u_stat (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.cap_stat  (cap_stat_ff),
		.cap_lock  (cap_lock_ff),
		.rd_byte   (cyc.rdata[7:0]),
		.summary   (summary),
		.lock_bits (lock_bits)
	);
endmodule

// ---- tb/fbls_host_assertions.sv ----
// Checker bound to the block-lock host controller top.
// Assumes an APB master that leaves one idle cycle between transfers.
`timescale 1ns/10ps
module fbls_host_chk #(
	parameter int ADDR_W = 22,
	parameter int DATA_W = 16
) (
	input wire logic              clk_sys,
	input wire logic              rst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [ADDR_W-1:0] fl_addr,
	input wire logic [DATA_W-1:0] fl_dq_o,
	input wire logic              fl_dq_oe_n,
	input wire logic              fl_ce_n,
	input wire logic              fl_we_n,
	input wire logic              fl_oe_n,
	input wire logic              fl_wp,
	input wire logic              fl_rst_n
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////
	// Bus handshake and flash pin protocol.
	a_apb_wait: assert property (psel && !penable |=> ##1 pready)
		else $error("pready missing in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_slverr_map: assert property (pready |-> pslverr == !(paddr == fbls_pkg::OFF_CMD
		|| paddr == fbls_pkg::OFF_ADDR || paddr == fbls_pkg::OFF_PINS
		|| paddr == fbls_pkg::OFF_STAT))
		else $error("pslverr does not match the address map");
	a_strobe_excl: assert property (fl_we_n || fl_oe_n)
		else $error("write and output enable low together");
	a_we_width: assert property ($fell(fl_we_n) |-> !fl_we_n [*3] ##1 fl_we_n)
		else $error("write strobe width wrong");
	a_write_drive: assert property (!fl_we_n |-> !fl_dq_oe_n && fl_dq_o[15:8] == 8'h00)
		else $error("command not driven on the low lane");
	a_read_release: assert property (!fl_oe_n |-> fl_dq_oe_n && !fl_ce_n)
		else $error("data wire driven during a read");
	a_addr_hold: assert property (!fl_ce_n && !$past(fl_ce_n) |-> $stable(fl_addr))
		else $error("flash address moved inside a cycle");
	a_pins_follow: assert property (pready && pwrite && paddr == fbls_pkg::OFF_PINS |=>
		fl_wp == $past(pwdata[0]) && fl_rst_n == !$past(pwdata[1]))
		else $error("pin levels do not follow the pin register");

	// Main scenarios reached.
	c_unmapped: cover property (pready && pslverr);
	c_write: cover property ($fell(fl_we_n));
	c_read: cover property ($fell(fl_oe_n));
endmodule

bind fbls_host fbls_host_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_fbls_host_chk (
	.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr),
	.fl_dq_o(fl_dq_o), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
	.fl_oe_n(fl_oe_n), .fl_wp(fl_wp), .fl_rst_n(fl_rst_n));

// ---- tb/fbls_flash_model.sv ----
// Behavioural flash: per-block lock state, status byte and locking commands.
// Assumes blocks of 32 Kword selected by address bits 17 to 15.
`timescale 1ns/10ps
module fbls_flash_model (
	input  wire logic        clk_sys,
	input  wire logic [21:0] fl_addr,
	input  wire logic [15:0] fl_dq_o,
	input  wire logic        fl_dq_oe_n,
	input  wire logic        fl_ce_n,
	input  wire logic        fl_we_n,
	input  wire logic        fl_oe_n,
	input  wire logic        fl_wp,
	input  wire logic        fl_rst_n,
	input  wire logic [7:0]  inj,
	output logic [15:0]      dq
);
	logic [7:0]  lk;
	logic [7:0]  dn;
	logic [7:0]  sr;
	logic [1:0]  mode;
	logic        pend;
	logic [15:0] last = 16'h0000;

	// Power-up and device reset leave all blocks locked, lock-down clear.
	task automatic clr();
		lk = 8'hff;
		dn = 8'h00;
		sr = 8'h80;
		mode = 2'd0;
		pend = 1'b0;
	endtask
	initial clr();
	always @(negedge fl_rst_n) clr();

	// Status bits, error or suspend, set by the engine when the bench asks for them.
	always @(inj) sr = sr | inj;

	// Falling protect pin restores locked-down blocks.
	always @(negedge fl_wp) lk = lk | dn;

	// Commands latch on the rising write strobe; lock changes apply at once.
	always @(posedge fl_we_n)
	begin
		if (fl_ce_n === 1'b0 && fl_rst_n === 1'b1 && pend)
		begin
			pend = 1'b0;
			mode = 2'd1;
			case (fl_dq_o[7:0])
				8'h01: lk[fl_addr[17:15]] = 1'b1;
				8'hd0: lk[fl_addr[17:15]] &= dn[fl_addr[17:15]] & !fl_wp;
				8'h2f:
				begin
					lk[fl_addr[17:15]] = 1'b1;
					dn[fl_addr[17:15]] = 1'b1;
				end
				default: sr = sr | 8'h30;
			endcase
		end
		else if (fl_ce_n === 1'b0 && fl_rst_n === 1'b1)
			case (fl_dq_o[7:0])
				8'h60: pend = 1'b1;
				8'h70: mode = 2'd1;
				8'h50: sr = sr & 8'hc5;
				8'h90: mode = 2'd2;
				default: mode = 2'd0;
			endcase
	end

	// Read data; a released wire toggles every cycle.
	assign dq = !fl_dq_oe_n ? fl_dq_o : (fl_ce_n | fl_oe_n) ? ~last :
		mode == 2'd1 ? {8'h00, sr} : (mode == 2'd2 && fl_addr[14:0] == 15'd2) ?
		{14'h0, dn[fl_addr[17:15]], lk[fl_addr[17:15]]} : ~last;
	always @(posedge clk_sys) last <= dq;
endmodule

// ---- tb/tb.sv ----
// Testbench for the block-lock host controller against a flash model.
// Assumes the flash model on the pins; keeps its own reference of lock state.
`timescale 1ns/10ps
module tb;
	logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, inj, lk, dn, sr;
	logic [31:0] pwdata, prdata, seed, rd;
	logic [21:0] fl_addr;
	logic [15:0] fl_dq_o, fl_dq_i;
	logic        fl_dq_oe_n, fl_ce_n, fl_we_n, fl_oe_n, fl_wp, fl_rst_n;
	logic        wp, rf, er, ll, ld;
	int          fail_count;
	int          compares;

	fbls_host i_fbls_host (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe_n(fl_dq_oe_n),
		.fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
		.fl_wp(fl_wp), .fl_rst_n(fl_rst_n));
	fbls_flash_model i_fbls_flash_model (.clk_sys(clk_sys), .fl_addr(fl_addr),
		.fl_dq_o(fl_dq_o), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
		.fl_oe_n(fl_oe_n), .fl_wp(fl_wp), .fl_rst_n(fl_rst_n), .inj(inj), .dq(fl_dq_i));

	// Clock of 20 ns period.
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////
	// Shared tasks.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		rnd = seed;
	endfunction

	function automatic logic [31:0] ex(input logic [7:0] s);
		ex = {12'h0, ld, ll, rf, 1'b0, s[6], s[2], s[7] & s[1], s[7] & s[3],
			s[7] & s[5] & s[4], s[7] & s[5], s[7] & s[4], s[7], s[7:1], 1'b0};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wrap_up();
		if (fail_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One APB transfer; holds the request until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready_wait", 32'd2, n);
	endtask

	// Polls status until the sequencer is idle, then reads it afresh.
	task automatic idle();
		int n;
		n = 0;
		do
		begin
			apb(1'b0, fbls_pkg::OFF_STAT, 32'h0);
			n++;
		end
		while (rd[16] !== 1'b0 && n < 60);
		apb(1'b0, fbls_pkg::OFF_STAT, 32'h0);
	endtask

	task automatic run(input logic [2:0] op, input logic [7:0] c, input logic [2:0] b);
		rf = 1'b0;
		apb(1'b1, fbls_pkg::OFF_ADDR, {14'h0, b, 15'h0});
		apb(1'b1, fbls_pkg::OFF_CMD, {16'h0, c, 5'h0, op});
		idle();
	endtask

	// Lock command k (3 means none) on block b, then its lock bits are read back.
	task automatic lop(input logic [1:0] k, input logic [2:0] b);
		if (k == 2'd0)
			lk[b] = 1'b1;
		if (k == 2'd1)
			lk[b] = lk[b] & dn[b] & !wp;
		if (k == 2'd2)
		begin
			lk[b] = 1'b1;
			dn[b] = 1'b1;
		end
		if (k != 2'd3)
			run({1'b0, k}, 8'h00, b);
		run(fbls_pkg::OP_LOCK_READ, 8'h00, b);
		ll = lk[b];
		ld = dn[b];
		chk("lock_bits", {30'h0, ld, ll}, {30'h0, rd[19:18]});
	endtask

	task automatic stat();
		run(fbls_pkg::OP_STATUS, 8'h00, 3'd0);
		chk("status", ex(sr), rd);
	endtask

	task automatic pins(input logic [1:0] v);
		if (wp && !v[0])
			lk = lk | dn;
		if (v[1])
		begin
			lk = 8'hff;
			dn = 8'h00;
			sr = 8'h80;
		end
		wp = v[0];
		apb(1'b1, fbls_pkg::OFF_PINS, {30'h0, v});
		apb(1'b0, fbls_pkg::OFF_PINS, 32'h0);
		chk("pins", {30'h0, v}, rd);
	endtask

	////////////////////////////////////////
	// Main sequence.
	initial
	begin
		logic [31:0] r;
		logic [7:0]  v [4];
		v = '{8'h0b, 8'h31, 8'h12, 8'h44};
		{rst, psel, penable, pwrite, paddr, pwdata, inj} = {1'b1, 51'h0};
		{fail_count, compares, seed} = {32'd0, 32'd0, 32'd26800};
		{lk, dn, sr, wp, rf, ll, ld} = {8'hff, 8'h00, 8'h80, 4'b0010};
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		for (int b = 0; b < 8; b++)
			lop(2'd3, 3'(b));
		stat();
		apb(1'b0, 8'h10, 32'h0);
		chk("slverr", 32'h1, {31'h0, er});
		chk("unmapped", 32'h0, rd);
		apb(1'b1, fbls_pkg::OFF_CMD, 32'h7);
		idle();
		chk("refused", 32'h1, {31'h0, rd[17]});
		apb(1'b1, fbls_pkg::OFF_ADDR, 32'h8000);
		apb(1'b1, fbls_pkg::OFF_CMD, {29'h0, fbls_pkg::OP_LOCK});
		apb(1'b1, fbls_pkg::OFF_CMD, {29'h0, fbls_pkg::OP_UNLOCK});
		idle();
		chk("busy_refused", 32'h1, {31'h0, rd[17]});
		lop(2'd3, 3'd1);
		lop(2'd2, 3'd5);
		lop(2'd1, 3'd5);
		pins(2'b01);
		lop(2'd1, 3'd5);
		lop(2'd0, 3'd5);
		lop(2'd1, 3'd5);
		pins(2'b00);
		lop(2'd3, 3'd5);
		for (int i = 0; i < 40; i++)
		begin
			r = rnd();
			if (r[4:3] == 2'd3)
				pins({1'b0, r[5]});
			lop(r[4:3] == 2'd3 ? 2'd1 : r[4:3], r[2:0]);
		end
		run(fbls_pkg::OP_RAW, fbls_pkg::FC_CONF_SETUP, 3'd2);
		run(fbls_pkg::OP_RAW, 8'hff, 3'd2);
		sr = sr | 8'h30;
		stat();
		foreach (v[i])
		begin
			inj <= v[i];
			sr = sr | v[i];
			stat();
			inj <= 8'h00;
			run(fbls_pkg::OP_CLEAR, 8'h00, 3'd0);
			sr = sr & 8'hc5;
			stat();
		end
		pins(2'b10);
		pins(2'b00);
		for (int b = 0; b < 8; b++)
			lop(2'd3, 3'(b));
		wrap_up();
	end

	// Cuts a hang short.
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		fail_count++;
		wrap_up();
	end
endmodule
